// ### shared/ide_cfg_regs.svh
// Purpose: offsets, field positions and reset values of the IDE configuration bank
// Assumes: offsets are configuration-space byte addresses, dword aligned on decode
// Notes:   definitions only
`ifndef IDE_CFG_REGS_SVH
`define IDE_CFG_REGS_SVH

`define OFF_SEC_CS_BASE      8'h1C
`define OFF_INT_LINE         8'h3C
`define OFF_INT_PIN          8'h3D
`define OFF_BUF_CTRL         8'h40
`define OFF_STRAP_CFG        8'h44
`define OFF_PCI_INT_ROUTE    8'h50

`define SEC_CS_BASE_LSB      3
`define SEC_CS_IO_SPACE      1'b1
`define INT_LINE_RST         8'h00
`define INT_PIN_VALUE        8'h02
`define BUF_CTRL_RST         8'h00
`define STRAP_CFG_OFF_VALUE  8'h00
`define PCI_INT_ROUTE_RST    2'h0

`define STRAP_HW_CFG_BIT     0
`define STRAP_BUF_BIT        7
`define ROUTE_PRI_BIT        0
`define ROUTE_SEC_BIT        1

`endif

// ### shared/ide_cfg_pkg.sv
// Purpose: types shared by the IDE configuration bank
// Assumes: nothing beyond the register header
// Notes:   the whole block state is one packed struct
`default_nettype none
package ide_cfg_pkg;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic        done;
        logic [28:0] sec_cs_base;
        logic [7:0]  int_line;
        logic [7:0]  buf_ctrl;
        logic [7:0]  strap_cfg;
        logic [1:0]  route_en;
        logic        intb_n;
        logic        ack;
        logic [31:0] rdata;
    } cfg_state_s;

endpackage
`default_nettype wire

// ### hw/ide_cfg_bank.sv
// Purpose: IDE function configuration registers 1Ch, 3Ch-3Dh, 40h, 44h, 50h
// Assumes: configuration cycles are presented one cycle wide, synchronous to REF_CLK_IN
// Notes:   one-cycle answer; strap byte caught on the first edge after reset release
//
// Behaviour
// RQ1 - secondary control/status base bits 31:3 writable, giving an 8-byte window
// RQ2 - base bits 2:1 read zero, bit 0 reads one for I/O space
// RQ3 - host reaches alternate status at window offset 6h; two bytes decoded
// RQ4 - interrupt line byte at 3Ch, read/write, resets to 00h, informational only
// RQ5 - firmware writes the interrupt line byte with the wired request level
// RQ6 - interrupts go out on shared INTB# or on legacy direct lines
// RQ7 - in legacy scheme software leaves line and PCI routing at zero
// RQ8 - interrupt pin byte at 3Dh always reads 02h
// RQ9 - PCI interrupt signalling gated per channel by routing enables at 50h
// RQ10 - buffering byte at 40h resets 00h; bits 7:4 secondary prefetch and post-write
// RQ11 - bits 3:0 are primary drive 1/0 prefetch and drive 1/0 post-write
// RQ12 - primary buffering bits preload from strap bit 7 when hardware config enabled
// RQ13 - strap byte at 44h caught from socket or common data lines by mode
// RQ14 - strap capture happens only when the global enable pin permits
// RQ15 - captured strap byte is the preload default for IDE timing
// RQ16 - with strap line 0 high, strap bit 7 enables primary buffering
// RQ17 - with strap line 0 low, bit 7 only reports the sampled line
// RQ18 - strap bit 0 written later selects compatible ranges or base registers
// RQ19 - writes to read-only or reserved bits ignored; reserved bits read zero
`include "ide_cfg_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module ide_cfg_bank
    import ide_cfg_pkg::*;
(
    input  wire logic        REF_CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire cfg_req_s    CFG_REQ_IN,
    input  wire logic [7:0]  STRAP_SOCKET_A_IN,
    input  wire logic [7:0]  STRAP_COMMON_IN,
    input  wire logic        FOUR_SOCKET_MODE_IN,
    input  wire logic        HW_CFG_PIN_EN_IN,
    input  wire logic        PRI_IDE_IRQ_IN,
    input  wire logic        SEC_IDE_IRQ_IN,
    output logic             CFG_ACK_OUT,
    output logic [31:0]      CFG_RDATA_OUT,
    output logic [31:0]      SEC_CS_BASE_OUT,
    output logic [7:0]       BUF_CTRL_OUT,
    output logic [7:0]       STRAP_CFG_OUT,
    output logic             COMPAT_SELECT_OUT,
    output logic             PCI_INTB_N_OUT
);

    cfg_state_s s_q;
    cfg_state_s s_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    function automatic logic [7:0] lane0(input logic [7:0] old, input cfg_req_s r);
        lane0 = r.be[0] ? r.wdata[7:0] : old;
    endfunction

    logic [7:0] strap_src;
    logic       req_ok;
    logic       wr_ok;

    always_comb begin
        // mode picks which data lines carry the straps
        strap_src = FOUR_SOCKET_MODE_IN ? STRAP_COMMON_IN : STRAP_SOCKET_A_IN; // RQ13
        // requests are dropped until the strap byte is in, so a write cannot race the capture
        req_ok    = CFG_REQ_IN.sel && s_q.done;
        wr_ok     = req_ok && CFG_REQ_IN.wr;
        s_d       = s_q;
        s_d.ack   = req_ok;
        s_d.rdata = s_q.rdata;

        if (!s_q.done) begin
            s_d.done = 1'b1;
            if (HW_CFG_PIN_EN_IN) begin
                s_d.strap_cfg = strap_src; // RQ14 RQ17
            end else begin
                s_d.strap_cfg = `STRAP_CFG_OFF_VALUE; // RQ14
            end
            // primary buffering preload only when hardware configuration is on
            s_d.buf_ctrl[3:0] = {4{HW_CFG_PIN_EN_IN && strap_src[`STRAP_HW_CFG_BIT]
                                   && strap_src[`STRAP_BUF_BIT]}}; // RQ12 RQ16
        end

        // one request per cycle, so a write and a read never meet in one edge
        if (wr_ok) begin
            if (hit(CFG_REQ_IN.addr, `OFF_SEC_CS_BASE)) begin
                // bits 2:0 are fixed; only 31:3 store
                if (CFG_REQ_IN.be[0]) s_d.sec_cs_base[4:0] = CFG_REQ_IN.wdata[7:3]; // RQ1 RQ19
                if (CFG_REQ_IN.be[1]) s_d.sec_cs_base[12:5] = CFG_REQ_IN.wdata[15:8]; // RQ1
                if (CFG_REQ_IN.be[2]) s_d.sec_cs_base[20:13] = CFG_REQ_IN.wdata[23:16]; // RQ1
                if (CFG_REQ_IN.be[3]) s_d.sec_cs_base[28:21] = CFG_REQ_IN.wdata[31:24]; // RQ1
            end else if (hit(CFG_REQ_IN.addr, `OFF_INT_LINE)) begin
                s_d.int_line = lane0(s_q.int_line, CFG_REQ_IN); // RQ4 RQ19
            end else if (hit(CFG_REQ_IN.addr, `OFF_BUF_CTRL)) begin
                s_d.buf_ctrl = lane0(s_q.buf_ctrl, CFG_REQ_IN); // RQ10 RQ11
            end else if (hit(CFG_REQ_IN.addr, `OFF_STRAP_CFG)) begin
                s_d.strap_cfg = lane0(s_q.strap_cfg, CFG_REQ_IN); // RQ18
            end else if (hit(CFG_REQ_IN.addr, `OFF_PCI_INT_ROUTE)) begin
                if (CFG_REQ_IN.be[0]) s_d.route_en = CFG_REQ_IN.wdata[1:0]; // RQ9
            end
        end

        if (req_ok && !CFG_REQ_IN.wr) begin
            if (hit(CFG_REQ_IN.addr, `OFF_SEC_CS_BASE)) begin
                s_d.rdata = {s_q.sec_cs_base, 2'b00, `SEC_CS_IO_SPACE}; // RQ2
            end else if (hit(CFG_REQ_IN.addr, `OFF_INT_LINE)) begin
                s_d.rdata = {16'h0000, `INT_PIN_VALUE, s_q.int_line}; // RQ8
            end else if (hit(CFG_REQ_IN.addr, `OFF_BUF_CTRL)) begin
                s_d.rdata = {24'h000000, s_q.buf_ctrl};
            end else if (hit(CFG_REQ_IN.addr, `OFF_STRAP_CFG)) begin
                s_d.rdata = {24'h000000, s_q.strap_cfg};
            end else if (hit(CFG_REQ_IN.addr, `OFF_PCI_INT_ROUTE)) begin
                s_d.rdata = {30'h00000000, s_q.route_en}; // RQ19
            end else begin
                s_d.rdata = 32'h00000000;
            end
        end

        // shared line is active low; each channel passes only when routed
        s_d.intb_n = !((PRI_IDE_IRQ_IN && s_q.route_en[`ROUTE_PRI_BIT])
                    || (SEC_IDE_IRQ_IN && s_q.route_en[`ROUTE_SEC_BIT])); // RQ6 RQ9
    end

    // async reset loads constants only; straps are caught on the first clocked
    // edge instead, so a strap line glitch during reset cannot corrupt state
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            s_q.done        <= 1'b0;
            s_q.sec_cs_base <= 29'h00000000;
            s_q.int_line    <= `INT_LINE_RST; // RQ4
            s_q.buf_ctrl    <= `BUF_CTRL_RST; // RQ10
            s_q.strap_cfg   <= `STRAP_CFG_OFF_VALUE;
            s_q.route_en    <= `PCI_INT_ROUTE_RST;
            s_q.intb_n      <= 1'b1;
            s_q.ack         <= 1'b0;
            s_q.rdata       <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    assign CFG_ACK_OUT       = s_q.ack;
    assign CFG_RDATA_OUT     = s_q.rdata;
    assign SEC_CS_BASE_OUT   = {s_q.sec_cs_base, 2'b00, `SEC_CS_IO_SPACE};
    assign BUF_CTRL_OUT      = s_q.buf_ctrl;
    assign STRAP_CFG_OUT     = s_q.strap_cfg; // RQ15
    assign COMPAT_SELECT_OUT = s_q.strap_cfg[`STRAP_HW_CFG_BIT]; // RQ18
    assign PCI_INTB_N_OUT    = s_q.intb_n;

    logic rd_base;
    logic rd_pin;
    assign rd_base = CFG_REQ_IN.sel && !CFG_REQ_IN.wr && hit(CFG_REQ_IN.addr, `OFF_SEC_CS_BASE);
    assign rd_pin  = CFG_REQ_IN.sel && !CFG_REQ_IN.wr && hit(CFG_REQ_IN.addr, `OFF_INT_LINE);

    a_base_io_bits: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ2
        SEC_CS_BASE_OUT[2:0] == 3'h1)
        else $error("base low bits not 001");

    a_base_read_back: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ1
        rd_base && s_q.done |=> CFG_ACK_OUT && CFG_RDATA_OUT == SEC_CS_BASE_OUT)
        else $error("base read mismatch");

    a_pin_reads_two: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ8
        rd_pin && s_q.done |=> CFG_RDATA_OUT[15:8] == 8'h02 && CFG_RDATA_OUT[31:16] == 16'h0)
        else $error("interrupt pin not 02h");

    a_line_holds_write: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ4
        s_q.done && CFG_REQ_IN.sel && CFG_REQ_IN.wr && CFG_REQ_IN.be[0]
        && hit(CFG_REQ_IN.addr, `OFF_INT_LINE)
        |=> s_q.int_line == $past(CFG_REQ_IN.wdata[7:0]))
        else $error("interrupt line write lost");

    a_intb_gating: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ9
        ##1 PCI_INTB_N_OUT == !(($past(PRI_IDE_IRQ_IN) && $past(s_q.route_en[0]))
                             || ($past(SEC_IDE_IRQ_IN) && $past(s_q.route_en[1]))))
        else $error("INTB not gated by routing enables");

    a_strap_capture: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ13
        !s_q.done && HW_CFG_PIN_EN_IN |=> STRAP_CFG_OUT ==
            $past(FOUR_SOCKET_MODE_IN ? STRAP_COMMON_IN : STRAP_SOCKET_A_IN))
        else $error("strap byte not captured");

    a_strap_disabled: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ14
        !s_q.done && !HW_CFG_PIN_EN_IN |=> STRAP_CFG_OUT == 8'h00 && BUF_CTRL_OUT == 8'h00)
        else $error("capture happened while disabled");

    a_buf_preload: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ12
        !s_q.done |=> BUF_CTRL_OUT[3:0] == {4{STRAP_CFG_OUT[0] && STRAP_CFG_OUT[7]}}
                      && BUF_CTRL_OUT[7:4] == 4'h0)
        else $error("primary buffering preload wrong");

    a_route_reserved: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ19
        CFG_REQ_IN.sel && !CFG_REQ_IN.wr && s_q.done && hit(CFG_REQ_IN.addr, `OFF_PCI_INT_ROUTE)
        |=> CFG_ACK_OUT && CFG_RDATA_OUT[31:2] == 30'h00000000)
        else $error("routing read answer malformed");

    // helper decodes for the checks below; the logic above does not read them
    logic wr_any;
    logic rd_any;
    logic rd_none;
    logic wr_base;
    logic wr_buf;
    logic wr_strap;
    logic wr_route;
    assign wr_any   = CFG_REQ_IN.sel && CFG_REQ_IN.wr && s_q.done;
    assign rd_any   = CFG_REQ_IN.sel && !CFG_REQ_IN.wr && s_q.done;
    assign wr_base  = wr_any && hit(CFG_REQ_IN.addr, `OFF_SEC_CS_BASE);
    assign wr_buf   = wr_any && hit(CFG_REQ_IN.addr, `OFF_BUF_CTRL);
    assign wr_strap = wr_any && hit(CFG_REQ_IN.addr, `OFF_STRAP_CFG);
    assign wr_route = wr_any && hit(CFG_REQ_IN.addr, `OFF_PCI_INT_ROUTE);
    assign rd_none  = rd_any
                   && !hit(CFG_REQ_IN.addr, `OFF_SEC_CS_BASE)
                   && !hit(CFG_REQ_IN.addr, `OFF_INT_LINE)
                   && !hit(CFG_REQ_IN.addr, `OFF_BUF_CTRL)
                   && !hit(CFG_REQ_IN.addr, `OFF_STRAP_CFG)
                   && !hit(CFG_REQ_IN.addr, `OFF_PCI_INT_ROUTE);

    // acknowledge timing
    a_ack_follows_req: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ19
        wr_any || rd_any
        |=> CFG_ACK_OUT)
        else $error("accepted request got no acknowledge");

    a_ack_single_pulse: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ19
        !(wr_any || rd_any)
        |=> !CFG_ACK_OUT)
        else $error("acknowledge without accepted request");

    a_capture_drops_req: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ14
        !s_q.done
        |=> !CFG_ACK_OUT)
        else $error("request answered during strap capture");

    // register write, unmapped read and hold behaviour
    a_base_full_write: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ1
        wr_base && CFG_REQ_IN.be == 4'hF
        |=> SEC_CS_BASE_OUT[31:3] == $past(CFG_REQ_IN.wdata[31:3]))
        else $error("base write not stored");

    a_buf_write: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ10
        wr_buf && CFG_REQ_IN.be[0]
        |=> BUF_CTRL_OUT == $past(CFG_REQ_IN.wdata[7:0]))
        else $error("buffering write not stored");

    a_strap_write: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ18
        wr_strap && CFG_REQ_IN.be[0]
        |=> STRAP_CFG_OUT == $past(CFG_REQ_IN.wdata[7:0]) && COMPAT_SELECT_OUT == $past(CFG_REQ_IN.wdata[0]))
        else $error("strap byte write not stored");

    a_route_write: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ9
        wr_route && CFG_REQ_IN.be[0]
        |=> s_q.route_en == $past(CFG_REQ_IN.wdata[1:0]))
        else $error("routing enables not stored");

    a_unmapped_zero: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ19
        rd_none
        |=> CFG_ACK_OUT && CFG_RDATA_OUT == 32'h00000000)
        else $error("unmapped read not zero");

    a_regs_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ4
        s_q.done && !wr_any
        |=> $stable(BUF_CTRL_OUT) && $stable(STRAP_CFG_OUT)
            && $stable(SEC_CS_BASE_OUT) && $stable(s_q.int_line))
        else $error("register changed without a write");

    a_rdata_holds: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ19
        !rd_any
        |=> $stable(CFG_RDATA_OUT))
        else $error("read data changed without a read");

    // strap capture
    a_strap_line0_low: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ17
        !s_q.done && HW_CFG_PIN_EN_IN && !strap_src[0]
        |=> BUF_CTRL_OUT[3:0] == 4'h0 && STRAP_CFG_OUT[7] == $past(strap_src[7]))
        else $error("strap bit 7 used with line 0 low");

    a_strap_line0_high: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ16
        !s_q.done && HW_CFG_PIN_EN_IN && strap_src[0]
        |=> BUF_CTRL_OUT[3:0] == {4{$past(strap_src[7])}})
        else $error("strap bit 7 not applied with line 0 high");

    // shared interrupt
    a_intb_idle: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ9
        s_q.route_en == 2'h0
        |=> PCI_INTB_N_OUT)
        else $error("shared interrupt active with routing off");

    a_intb_follows_pri: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ6
        PRI_IDE_IRQ_IN && s_q.route_en[0]
        |=> !PCI_INTB_N_OUT)
        else $error("primary request not on shared line");

    a_intb_follows_sec: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN) // RQ6
        SEC_IDE_IRQ_IN && s_q.route_en[1]
        |=> !PCI_INTB_N_OUT)
        else $error("secondary request not on shared line");

endmodule
`default_nettype wire

// ### tb/cfg_host_model.sv
// Purpose: configuration host issuing one-cycle requests to the IDE bank
// Assumes: answer comes on the same edge that takes the request, one edge after it is driven
// Notes:   released request fields show inverted values, never stale ones
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model
    import ide_cfg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [31:0] rdata_in,
    output var  cfg_req_s    req_out
);
    initial req_out = '0;
    // sel stands one cycle only; a longer strobe would count as a second request
    task automatic acc(input logic w, input logic [7:0] ad, input logic [3:0] be,
                       input logic [31:0] wd, output logic ack, output logic [31:0] rd);
        @(posedge clk_in);
        req_out <= '{sel: 1'b1, wr: w, addr: ad, be: be, wdata: wd};
        @(posedge clk_in);
        req_out <= '{sel: 1'b0, wr: ~w, addr: ~ad, be: ~be, wdata: ~wd};
        #1;
        ack = ack_in;
        rd = rdata_in;
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench for the IDE configuration bank
// Assumes: straps are stable for the whole reset pulse
// Notes:   each reset uses a different strap set to reach every preload path
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, v) begin check_count++; if ((v) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, v); end end
module tb
    import ide_cfg_pkg::*;
;
    logic        clk, rstn, four, pin, pri_irq, sec_irq, ack, compat, intb_n, a;
    logic [7:0]  sock_a, common, buf_ctrl, strap;
    logic [31:0] rdata, sec_base, rd;
    cfg_req_s    req;
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles = 0;

    cfg_host_model host (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .req_out(req));
    ide_cfg_bank dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .CFG_REQ_IN(req),
        .STRAP_SOCKET_A_IN(sock_a), .STRAP_COMMON_IN(common), .FOUR_SOCKET_MODE_IN(four),
        .HW_CFG_PIN_EN_IN(pin), .PRI_IDE_IRQ_IN(pri_irq), .SEC_IDE_IRQ_IN(sec_irq),
        .CFG_ACK_OUT(ack), .CFG_RDATA_OUT(rdata), .SEC_CS_BASE_OUT(sec_base),
        .BUF_CTRL_OUT(buf_ctrl), .STRAP_CFG_OUT(strap), .COMPAT_SELECT_OUT(compat),
        .PCI_INTB_N_OUT(intb_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic do_reset(input logic p, input logic m, input logic [7:0] sa, input logic [7:0] sc);
        @(posedge clk);
        rstn <= 1'b0;
        pin <= p;
        four <= m;
        sock_a <= sa;
        common <= sc;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic cfg(input logic w, input logic [7:0] ad, input logic [3:0] be, input logic [31:0] wd);
        host.acc(w, ad, be, wd, a, rd);
    endtask

    task automatic t_defaults();
        do_reset(1'b0, 1'b0, 8'hFF, 8'hFF);
        `CHK("strap", 8'h00, strap);
        `CHK("buf", 8'h00, buf_ctrl);
        `CHK("base", 32'h0000_0001, sec_base);
        `CHK("intb", 1'b1, intb_n);
        cfg(1'b0, 8'h3C, 4'hF, 32'h0);
        `CHK("ack", 1'b1, a);
        `CHK("line_pin", 32'h0000_0200, rd);
    endtask

    task automatic t_straps();
        do_reset(1'b1, 1'b0, 8'h81, 8'h00);
        `CHK("strap_a", 8'h81, strap);
        `CHK("buf_pre", 8'h0F, buf_ctrl);
        `CHK("compat", 1'b1, compat);
        do_reset(1'b1, 1'b1, 8'h81, 8'h80);
        `CHK("strap_c", 8'h80, strap);
        `CHK("buf_off", 8'h00, buf_ctrl);
        do_reset(1'b1, 1'b0, 8'h01, 8'hFF);
        `CHK("buf_dis", 8'h00, buf_ctrl);
        `CHK("timing_pre", 8'h01, strap);
    endtask

    task automatic t_regs();
        cfg(1'b1, 8'h1C, 4'hF, 32'hFFFF_FFFF);
        `CHK("base_out", 32'hFFFF_FFF9, sec_base);
        cfg(1'b0, 8'h1C, 4'hF, 32'h0);
        `CHK("base_rd", 32'hFFFF_FFF9, rd);
        cfg(1'b1, 8'h1C, 4'hF, 32'h0000_0376);
        `CHK("alt_status", 32'h0000_0376, (sec_base & 32'hFFFF_FFF8) + 32'h0000_0006);
        cfg(1'b1, 8'h3C, 4'h3, 32'h0000_AA5A);
        cfg(1'b0, 8'h3C, 4'hF, 32'h0);
        `CHK("line_wr", 32'h0000_025A, rd);
        cfg(1'b1, 8'h40, 4'h1, 32'h0000_00A5);
        `CHK("buf_out", 8'hA5, buf_ctrl);
        cfg(1'b0, 8'h40, 4'hF, 32'h0);
        `CHK("buf_rd", 32'h0000_00A5, rd);
        cfg(1'b1, 8'h44, 4'h1, 32'h0);
        `CHK("compat_wr", 1'b0, compat);
        cfg(1'b0, 8'h60, 4'hF, 32'h0);
        `CHK("unmapped", 32'h0, rd);
    endtask

    task automatic t_irq();
        @(posedge clk);
        pri_irq <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK("intb_gated", 1'b1, intb_n);
        cfg(1'b1, 8'h50, 4'h1, 32'h0000_00FF);
        cfg(1'b0, 8'h50, 4'hF, 32'h0);
        `CHK("route_rd", 32'h0000_0003, rd);
        `CHK("intb_pri", 1'b0, intb_n);
        cfg(1'b1, 8'h50, 4'h1, 32'h0000_0002);
        repeat (2) @(posedge clk);
        #1;
        `CHK("intb_sec_only", 1'b1, intb_n);
        @(posedge clk);
        sec_irq <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK("intb_sec", 1'b0, intb_n);
        cfg(1'b1, 8'h50, 4'h1, 32'h0);
        cfg(1'b1, 8'h3C, 4'h1, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        `CHK("intb_legacy", 1'b1, intb_n);
    endtask

    initial begin
        rstn = 1'b0;
        {four, pin, pri_irq, sec_irq} = 4'h0;
        sock_a = 8'h00;
        common = 8'h00;
        t_defaults();
        t_straps();
        t_regs();
        t_irq();
        end_sim();
    end
endmodule
`default_nettype wire
